// ===== bench/hpp_assertions.sv
// Concurrent checks on the host parallel port
module hpp_assertions
    import hpp_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // Host side
    input wire logic        chip_select_n_i,
    input wire logic        data_strobe_one_i,
    input wire logic        data_strobe_two_i,
    input wire logic        narrow_16bit_mode_i,
    input wire logic [31:0] host_data_bus_o,
    input wire logic        host_data_bus_oe_o,
    input wire logic        port_ready_n_o,
    // CPU and DMA side
    input wire logic        cpu_req_i,
    input wire logic        cpu_we_i,
    input wire logic [31:0] cpu_addr_i,
    input wire logic        cpu_ack_o,
    input wire logic [31:0] cpu_rdata_o,
    input wire logic        dma_req_o,
    input wire logic        dma_we_o,
    input wire logic [31:0] dma_addr_o,
    input wire logic [2:0]  dma_priority_o,
    input wire logic        dma_ack_i,
    input wire logic [31:0] dma_rdata_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic idle;
    logic mapped;
    // Strobe is idle when unselected or when both data strobes agree
    assign idle = chip_select_n_i | ~(data_strobe_one_i ^ data_strobe_two_i);
    assign mapped = cpu_addr_i inside {PORT_CONTROL_ADDR, WRITE_ADDR_CPY_ADDR,
                                       READ_ADDR_CPY_ADDR, XFER_REQ_CTRL_ADDR};
    reset_quiet_a: assert property ($rose(rst_n_i) |-> !port_ready_n_o && !dma_req_o)
        else $error("port active right after reset");
    cpu_ack_a: assert property (cpu_req_i |=> cpu_ack_o)
        else $error("cpu access not acknowledged next cycle");
    unmapped_zero_a: assert property (cpu_req_i && !cpu_we_i && !mapped |=> !cpu_rdata_o)
        else $error("unmapped cpu read returned data");
    prio_source_a: assert property ($changed(dma_priority_o) |-> $past(cpu_req_i))
        else $error("priority changed without a cpu write");
    dma_hold_a: assert property (dma_req_o && !dma_ack_i |=>
        dma_req_o && $stable(dma_addr_o) && $stable(dma_we_o))
        else $error("dma request dropped or changed before ack");
    read_wait_a: assert property (dma_req_o && !dma_we_o |-> port_ready_n_o)
        else $error("ready low while read fetch pending");
    read_load_a: assert property (dma_req_o && dma_ack_i && !dma_we_o && !narrow_16bit_mode_i
        |=> !port_ready_n_o && host_data_bus_o == $past(dma_rdata_i))
        else $error("fetched word not presented with ready");
    idle_quiet_a: assert property (idle [*8] |-> !host_data_bus_oe_o)
        else $error("bus driven without an active strobe");
    narrow_upper_a: assert property (host_data_bus_oe_o && narrow_16bit_mode_i
        |-> host_data_bus_o[31:16] == 16'h0)
        else $error("upper half driven in narrow mode");
    cover property (dma_req_o && dma_ack_i && dma_we_o);
    cover property (dma_req_o && dma_ack_i && !dma_we_o);
    cover property (host_data_bus_oe_o && narrow_16bit_mode_i);
endmodule : hpp_assertions

bind hpp_host_parallel_port hpp_assertions chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(chip_select_n_i),
    .data_strobe_one_i(data_strobe_one_i), .data_strobe_two_i(data_strobe_two_i),
    .narrow_16bit_mode_i(narrow_16bit_mode_i), .host_data_bus_o(host_data_bus_o),
    .host_data_bus_oe_o(host_data_bus_oe_o), .port_ready_n_o(port_ready_n_o),
    .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i), .cpu_ack_o(cpu_ack_o),
    .cpu_rdata_o(cpu_rdata_o), .dma_req_o(dma_req_o), .dma_we_o(dma_we_o),
    .dma_addr_o(dma_addr_o), .dma_priority_o(dma_priority_o), .dma_ack_i(dma_ack_i),
    .dma_rdata_i(dma_rdata_i)
);

// ===== bench/hpp_host_model.sv
// Behavioural external host driving the port pins
module hpp_host_model
    import hpp_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Host pins
    output hpp_pins_t        pins_o,
    input  wire logic        ready_n_i,
    input  wire logic        oe_i,
    input  wire logic [31:0] data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_hang = 0, n_bad_oe = 0;
    initial
    begin
        pins_o = '{1'b1, 1'b1, 1'b1, 1'b1, SEL_CONTROL, 1'b1, 1'b0, 1'b0, 32'h0};
    end
    // The host opens every transfer; the port only answers
    task access(input hpp_sel_t sel, input logic rnw, input logic hw, input logic use_as,
                input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(negedge clk_i);
        pins_o.sel = sel;
        pins_o.rnw = rnw;
        pins_o.hw = hw;
        // Released bus on reads shows the inverse, never the old value
        pins_o.data = rnw ? ~pins_o.data : wd;
        pins_o.as_n = !use_as;
        @(negedge clk_i);
        pins_o.cs_n = 1'b0;
        pins_o.ds1 = 1'b0;
        @(negedge clk_i);
        pins_o.as_n = 1'b1;
        repeat (5) @(negedge clk_i);
        n = 0;
        while (ready_n_i !== 1'b0 && n < 400)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n == 400)
            n_hang++;
        rd = data_i;
        if (oe_i !== rnw)
            n_bad_oe++;
        pins_o.cs_n = 1'b1;
        pins_o.ds1 = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask : access
endmodule : hpp_host_model

// ===== bench/tb_top.sv
// Self-checking bench for the host parallel port
module tb_top
    import hpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, cpu_req_i = 1'b0, cpu_we_i = 1'b0;
    logic        dma_ack_i = 1'b0, cpu_ack_o, dma_req_o, dma_we_o, hd_oe, ready_n;
    logic [31:0] cpu_addr_i = 32'h0, cpu_wdata_i = 32'h0, dma_rdata_i = 32'h0;
    logic [31:0] cpu_rdata_o, dma_addr_o, dma_wdata_o, hd_o, rd;
    logic [2:0]  prio;
    hpp_pins_t   pins;
    logic [31:0] mem [logic [31:0]];
    int          n_mismatch = 0, n_compared = 0, n_dma_rd = 0, cyc = 0, dly = 2, cnt = 0, k;

    hpp_host_parallel_port dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_n_i(pins.cs_n),
        .data_strobe_one_i(pins.ds1), .data_strobe_two_i(pins.ds2), .addr_strobe_n_i(pins.as_n),
        .access_select_i(pins.sel), .read_not_write_i(pins.rnw), .halfword_select_i(pins.hw),
        .narrow_16bit_mode_i(pins.m16), .host_data_bus_i(pins.data), .host_data_bus_o(hd_o),
        .host_data_bus_oe_o(hd_oe), .port_ready_n_o(ready_n), .cpu_req_i(cpu_req_i),
        .cpu_we_i(cpu_we_i), .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i),
        .cpu_ack_o(cpu_ack_o), .cpu_rdata_o(cpu_rdata_o), .dma_req_o(dma_req_o),
        .dma_we_o(dma_we_o), .dma_addr_o(dma_addr_o), .dma_wdata_o(dma_wdata_o),
        .dma_priority_o(prio), .dma_ack_i(dma_ack_i), .dma_rdata_i(dma_rdata_i)
    );
    hpp_host_model host_u (.clk_i(clk_i), .pins_o(pins), .ready_n_i(ready_n),
        .oe_i(hd_oe), .data_i(hd_o));

    always #20 clk_i = ~clk_i;
    // --------------------------------------------------------------
    // DMA engine: answers each request after dly cycles
    // --------------------------------------------------------------
    always @(negedge clk_i)
    begin
        dma_ack_i <= dma_req_o && !dma_ack_i && cnt >= dly;
        cnt <= (dma_req_o && !dma_ack_i && cnt < dly) ? cnt + 1 : 0;
        if (dma_req_o && !dma_ack_i && cnt >= dly && dma_we_o)
            mem[dma_addr_o] = dma_wdata_o;
        if (dma_req_o && !dma_ack_i && cnt >= dly && !dma_we_o)
        begin
            dma_rdata_i <= mem.exists(dma_addr_o) ? mem[dma_addr_o] : ~dma_addr_o;
            n_dma_rd++;
        end
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cpu(input logic we, input logic [31:0] ad, input logic [31:0] wd);
        @(negedge clk_i);
        cpu_req_i = 1'b1;
        cpu_we_i = we;
        cpu_addr_i = ad;
        cpu_wdata_i = wd;
        @(negedge clk_i);
        cpu_req_i = 1'b0;
        rd = 'x;
        for (int i = 0; i < 3 && cpu_ack_o !== 1'b1; i++)
            @(negedge clk_i);
        rd = cpu_rdata_o;
    endtask : cpu
    task automatic cpu_rd(input logic [31:0] ad, input logic [31:0] exp, input string what);
        cpu(1'b0, ad, 32'h0);
        chk(what, exp, rd);
    endtask : cpu_rd
    task automatic hwr(input hpp_sel_t sel, input logic hw, input logic as_on, input logic [31:0] wd);
        host_u.access(sel, 1'b0, hw, as_on, wd, rd);
    endtask : hwr
    task automatic hrd(input hpp_sel_t sel, input logic hw, input logic as_on,
                       input logic [31:0] exp, input string what);
        host_u.access(sel, 1'b1, hw, as_on, 32'h0, rd);
        chk(what, exp, rd);
    endtask : hrd
    // Waits for the write buffer to empty towards the DMA engine
    task automatic drain;
        for (int i = 0; i < 200 && (dma_req_o !== 1'b0 || ready_n !== 1'b0); i++)
            @(negedge clk_i);
    endtask : drain
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        cpu_rd(PORT_CONTROL_ADDR, CTRL_RESET, "ctrl");
        cpu_rd(WRITE_ADDR_CPY_ADDR, ADDR_RESET, "waddr");
        cpu_rd(XFER_REQ_CTRL_ADDR, TRCTL_RESET, "trctl");
        cpu_rd(32'h0188_000c, 32'h0, "unmapped");
        cpu(1'b1, WRITE_ADDR_CPY_ADDR, 32'h0000_1000);
        cpu(1'b1, READ_ADDR_CPY_ADDR, 32'h0000_2000);
        cpu(1'b1, XFER_REQ_CTRL_ADDR, 32'h0000_0005);
        cpu_rd(WRITE_ADDR_CPY_ADDR, 32'h0000_1000, "waddr");
        cpu_rd(READ_ADDR_CPY_ADDR, 32'h0000_2000, "raddr");
        chk("priority", 32'h5, {29'h0, prio});
        hwr(SEL_ADDRESS, 1'b0, 1'b1, 32'h01c0_0010);
        cpu_rd(WRITE_ADDR_CPY_ADDR, 32'h01c0_0010, "waddr");
        cpu_rd(READ_ADDR_CPY_ADDR, 32'h01c0_0010, "raddr");
        hrd(SEL_ADDRESS, 1'b0, 1'b0, 32'h01c0_0010, "addr");
        hrd(SEL_CONTROL, 1'b0, 1'b0, CTRL_RESET, "ctrl");
        hwr(SEL_CONTROL, 1'b0, 1'b0, 32'h0000_0040);
        cpu_rd(PORT_CONTROL_ADDR, 32'h0000_0040, "ctrl host");
        dly = 12;
        hwr(SEL_DATA_INC, 1'b0, 1'b0, 32'hcafe_0001);
        hwr(SEL_DATA_INC, 1'b0, 1'b0, 32'hcafe_0002);
        drain();
        chk("mem0", 32'hcafe_0001, mem[32'h01c0_0010]);
        chk("mem1", 32'hcafe_0002, mem[32'h01c0_0014]);
        cpu_rd(WRITE_ADDR_CPY_ADDR, 32'h01c0_0018, "waddr");
        dly = 20;
        hwr(SEL_ADDRESS, 1'b0, 1'b0, 32'h01c0_0010);
        k = n_dma_rd;
        hrd(SEL_DATA_INC, 1'b0, 1'b0, 32'hcafe_0001, "read inc");
        hrd(SEL_DATA_FIX, 1'b0, 1'b1, 32'hcafe_0002, "read fix");
        hrd(SEL_DATA_FIX, 1'b0, 1'b0, 32'hcafe_0002, "read again");
        chk("dma reads", 32'd3, n_dma_rd - k);
        cpu_rd(READ_ADDR_CPY_ADDR, 32'h01c0_0014, "raddr");
        @(negedge clk_i);
        host_u.pins_o.cs_n = 1'b0;
        host_u.pins_o.ds2 = 1'b0;
        host_u.pins_o.ds1 = 1'b0;
        repeat (10) @(negedge clk_i);
        chk("both strobes", 32'h0, {31'h0, hd_oe});
        host_u.pins_o.cs_n = 1'b1;
        host_u.pins_o.ds2 = 1'b1;
        repeat (10) @(negedge clk_i);
        chk("unselected", 32'h0, {31'h0, hd_oe});
        host_u.pins_o.ds1 = 1'b1;
        rst_n_i = 1'b0;
        host_u.pins_o.m16 = 1'b1;
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        hwr(SEL_ADDRESS, 1'b0, 1'b0, 32'h0000_0020);
        hwr(SEL_ADDRESS, 1'b1, 1'b0, 32'h0000_01c0);
        cpu_rd(READ_ADDR_CPY_ADDR, 32'h01c0_0020, "raddr narrow");
        hwr(SEL_DATA_FIX, 1'b0, 1'b0, 32'h0000_beef);
        hwr(SEL_DATA_FIX, 1'b1, 1'b0, 32'h0000_f00d);
        drain();
        chk("mem narrow", 32'hf00d_beef, mem[32'h01c0_0020]);
        k = n_dma_rd;
        hrd(SEL_DATA_FIX, 1'b0, 1'b1, 32'h0000_beef, "half first");
        hrd(SEL_DATA_FIX, 1'b1, 1'b0, 32'h0000_f00d, "half second");
        chk("dma reads narrow", 32'd1, n_dma_rd - k);
        chk("hang", 32'd0, host_u.n_hang);
        chk("bus drive", 32'd0, host_u.n_bad_oe);
        final_report();
    end
endmodule : tb_top

// ===== core/hpp_host_parallel_port.sv
// Host parallel port: host pin slave, CPU register access, DMA requests
//
// Function
// - Host always initiates; the port only answers host reads and writes.
// - Every host memory word access goes out as one request to the DMA engine; halfword pairs share it.
// - Peripheral registers are reached through the port like ordinary memory.
// - Control and address registers are read/write by CPU and by host.
// - Data window has no CPU address; only the host reaches it.
// - Host address write loads write copy and read copy together.
// - CPU reads and writes the two address copies at separate addresses.
// - Strobe is low when chip select low and exactly one data strobe low.
// - Access select, read-not-write, and in 16-bit mode halfword select, are sampled.
// - 16-bit and 32-bit modes; address strobe pulsed or held high.
// - Data read at first strobe fall of a word issues a DMA read.
// - Ready stays high on a data read until DMA loads the data.
// - Ready stays high on a data write while the write buffer is full.
// - Second halfword read comes from fetched data with no new DMA request.
module hpp_host_parallel_port
    import hpp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Host pins
    input  wire logic        chip_select_n_i,
    input  wire logic        data_strobe_one_i,
    input  wire logic        data_strobe_two_i,
    input  wire logic        addr_strobe_n_i,
    input  wire logic [1:0]  access_select_i,
    input  wire logic        read_not_write_i,
    input  wire logic        halfword_select_i,
    input  wire logic        narrow_16bit_mode_i,
    input  wire logic [31:0] host_data_bus_i,
    output logic      [31:0] host_data_bus_o,
    output logic             host_data_bus_oe_o,
    output logic             port_ready_n_o,
    // CPU memory map
    input  wire logic        cpu_req_i,
    input  wire logic        cpu_we_i,
    input  wire logic [31:0] cpu_addr_i,
    input  wire logic [31:0] cpu_wdata_i,
    output logic             cpu_ack_o,
    output logic      [31:0] cpu_rdata_o,
    // DMA address engine
    output logic             dma_req_o,
    output logic             dma_we_o,
    output logic      [31:0] dma_addr_o,
    output logic      [31:0] dma_wdata_o,
    output logic      [2:0]  dma_priority_o,
    input  wire logic        dma_ack_i,
    input  wire logic [31:0] dma_rdata_i
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    hpp_regs_t r;
    hpp_regs_t next_r;

    logic        stb_n;
    logic        stb_fall;
    logic        stb_rise;
    logic        as_fall;

    hpp_cmd_t    cur_cmd;
    hpp_cmd_t    use_cmd;
    logic        mode16;
    logic        second;
    logic        hi_lane;
    logic        is_data;

    logic [31:0] ctrl_view;
    logic [31:0] old_word;
    logic [31:0] new_word;

    // Puts a word on the bus; in 16-bit mode only the chosen half, low lanes
    function automatic logic [31:0] lane_out(
        input logic [31:0] w,
        input logic        m16,
        input logic        hi
    );
        if (!m16)
            return w;
        return {16'h0000, (hi ? w[31:16] : w[15:0])};
    endfunction : lane_out

    // Merges a host write into an existing word
    function automatic logic [31:0] lane_in(
        input logic [31:0] old,
        input logic [31:0] d,
        input logic        m16,
        input logic        hi
    );
        if (!m16)
            return d;
        return hi ? {d[15:0], old[15:0]} : {old[31:16], d[15:0]};
    endfunction : lane_in

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;

        // Pins pass two flops before any logic looks at them
        next_r.s1.cs_n = chip_select_n_i;
        next_r.s1.ds1  = data_strobe_one_i;
        next_r.s1.ds2  = data_strobe_two_i;
        next_r.s1.as_n = addr_strobe_n_i;
        next_r.s1.sel  = hpp_sel_t'(access_select_i);
        next_r.s1.rnw  = read_not_write_i;
        next_r.s1.hw   = halfword_select_i;
        next_r.s1.m16  = narrow_16bit_mode_i;
        next_r.s1.data = host_data_bus_i;
        next_r.s2      = r.s1;

        // Edge flops reset to idle, so no false edge follows reset
        stb_n = ~(r.s2.ds1 ^ r.s2.ds2) | r.s2.cs_n;
        stb_fall = r.stb_q & ~stb_n;
        stb_rise = ~r.stb_q & stb_n;
        as_fall  = r.as_q & ~r.s2.as_n;
        next_r.stb_q = stb_n;
        next_r.as_q  = r.s2.as_n;

        mode16  = r.s2.m16;
        cur_cmd = '{sel: r.s2.sel, rnw: r.s2.rnw, hw: r.s2.hw};

        // A pulsed address strobe captures the selects early; held high it never
        // falls and the selects are taken at the strobe edge instead.
        if (as_fall && stb_n)
        begin
            next_r.cmd      = cur_cmd;
            next_r.cmd_held = 1'b1;
        end
        use_cmd = stb_fall ? (r.cmd_held ? r.cmd : cur_cmd) : r.cmd;

        second  = mode16 & use_cmd.hw;
        hi_lane = second ^ r.ctrl[CTRL_HALF_SWAP_BIT];
        is_data = (use_cmd.sel == SEL_DATA_INC) || (use_cmd.sel == SEL_DATA_FIX);

        ctrl_view = r.ctrl;
        ctrl_view[CTRL_WBUF_FULL_BIT]  = r.wbuf_full;
        ctrl_view[CTRL_FETCH_BUSY_BIT] = (r.st == ST_FETCH);

        // CPU side: the data window has no address here
        next_r.cpu_ack   = 1'b0;
        next_r.cpu_rdata = 32'h0000_0000;

        // Stray addresses still ack, so the CPU never stalls
        if (cpu_req_i)
        begin
            next_r.cpu_ack = 1'b1;
            if (cpu_we_i)
            begin
                unique case (cpu_addr_i)
                    PORT_CONTROL_ADDR:   next_r.ctrl  = cpu_wdata_i;
                    WRITE_ADDR_CPY_ADDR: next_r.waddr = cpu_wdata_i;
                    READ_ADDR_CPY_ADDR:  next_r.raddr = cpu_wdata_i;
                    XFER_REQ_CTRL_ADDR:  next_r.trctl = cpu_wdata_i;
                    default:             next_r.cpu_ack = 1'b1;
                endcase
            end
            else
            begin
                unique case (cpu_addr_i)
                    PORT_CONTROL_ADDR:   next_r.cpu_rdata = ctrl_view;
                    WRITE_ADDR_CPY_ADDR: next_r.cpu_rdata = r.waddr;
                    READ_ADDR_CPY_ADDR:  next_r.cpu_rdata = r.raddr;
                    XFER_REQ_CTRL_ADDR:  next_r.cpu_rdata = r.trctl;
                    default:             next_r.cpu_rdata = 32'h0000_0000;
                endcase
            end
        end

        // DMA engine: one request outstanding, buffered write goes first
        if (r.dma.req && dma_ack_i)
        begin
            next_r.dma.req = 1'b0;
            if (r.dma.we)
                next_r.wbuf_full = 1'b0;
            else
            begin
                next_r.rdata = dma_rdata_i;
                if (r.st == ST_FETCH)
                begin
                    next_r.hd_out  = lane_out(dma_rdata_i, mode16, r.ctrl[CTRL_HALF_SWAP_BIT]);
                    next_r.ready_n = 1'b0;
                    next_r.st      = ST_HOLD;
                end
                if (r.cmd.sel == SEL_DATA_INC)
                    next_r.raddr = r.raddr + ADDR_STEP;
            end
        end
        else if (!r.dma.req)
        begin
            if (r.wbuf_full)
            begin
                next_r.dma.req   = 1'b1;
                next_r.dma.we    = 1'b1;
                next_r.dma.addr  = r.wbuf_addr;
                next_r.dma.wdata = r.wbuf;
            end
            else if (r.st == ST_FETCH)
            begin
                next_r.dma.req  = 1'b1;
                next_r.dma.we   = 1'b0;
                next_r.dma.addr = r.raddr;
            end
        end

        // Host strobe falling: the access starts
        if (stb_fall)
        begin
            next_r.cmd = use_cmd;
            next_r.st  = ST_HOLD;

            if (use_cmd.rnw)
            begin
                next_r.hd_oe = 1'b1;
                if (is_data && !second)
                begin
                    next_r.st      = ST_FETCH;
                    next_r.ready_n = 1'b1;
                end
                else
                begin
                    unique case (use_cmd.sel)
                        SEL_CONTROL: next_r.hd_out = lane_out(ctrl_view, mode16, hi_lane);
                        SEL_ADDRESS: next_r.hd_out = lane_out(r.raddr, mode16, hi_lane);
                        SEL_DATA_INC,
                        SEL_DATA_FIX: next_r.hd_out = lane_out(r.rdata, mode16, hi_lane);
                    endcase
                    next_r.ready_n = 1'b0;
                end
            end
            else
                next_r.ready_n = is_data & r.wbuf_full;
        end
        else if (r.st == ST_HOLD && !r.cmd.rnw && !stb_n)
            // Ready comes back as soon as the buffer drains
            next_r.ready_n = ((r.cmd.sel == SEL_DATA_INC) || (r.cmd.sel == SEL_DATA_FIX))
                             & r.wbuf_full;

        // Host strobe rising: write data is taken here, bus released
        if (stb_rise)
        begin
            next_r.hd_oe    = 1'b0;
            next_r.ready_n  = 1'b0;
            next_r.st       = ST_IDLE;
            next_r.cmd_held = 1'b0;
            unique case (r.cmd.sel)
                SEL_CONTROL:  old_word = r.ctrl;
                SEL_ADDRESS:  old_word = r.waddr;
                SEL_DATA_INC,
                SEL_DATA_FIX: old_word = r.wstage;
            endcase

            new_word = lane_in(old_word, r.s2.data, mode16, hi_lane);

            if (!r.cmd.rnw)
            begin
                unique case (r.cmd.sel)
                    SEL_CONTROL: next_r.ctrl = new_word;
                    SEL_ADDRESS:
                    begin
                        next_r.waddr = new_word;
                        next_r.raddr = new_word;
                    end
                    SEL_DATA_INC,
                    SEL_DATA_FIX:
                    begin
                        if (!mode16 || second)
                        begin
                            // Buffer is empty here because ready was low
                            next_r.wbuf      = new_word;
                            next_r.wbuf_addr = r.waddr;
                            next_r.wbuf_full = 1'b1;
                            if (r.cmd.sel == SEL_DATA_INC)
                                next_r.waddr = r.waddr + ADDR_STEP;
                        end
                        else
                            next_r.wstage = new_word;
                    end
                endcase
            end
        end
        else
        begin
            old_word = r.wstage;
            new_word = r.wstage;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            r          <= '0;
            // Chip select and address strobe sync stages start at the idle pin level
            r.s1.cs_n  <= 1'b1;
            r.s2.cs_n  <= 1'b1;
            r.s1.as_n  <= 1'b1;
            r.s2.as_n  <= 1'b1;
            r.stb_q    <= 1'b1;
            r.as_q     <= 1'b1;
            r.st       <= ST_IDLE;
            r.ctrl     <= CTRL_RESET;
            r.waddr    <= ADDR_RESET;
            r.raddr    <= ADDR_RESET;
            r.trctl    <= TRCTL_RESET;
        end
        else
            r <= next_r;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign host_data_bus_o    = r.hd_out;
    assign host_data_bus_oe_o = r.hd_oe;
    assign port_ready_n_o     = r.ready_n;

    assign cpu_ack_o          = r.cpu_ack;
    assign cpu_rdata_o        = r.cpu_rdata;

    assign dma_req_o          = r.dma.req;
    assign dma_we_o           = r.dma.we;
    assign dma_addr_o         = r.dma.addr;
    assign dma_wdata_o        = r.dma.wdata;
    assign dma_priority_o     = r.trctl[TRCTL_PRI_LSB +: TRCTL_PRI_W];

endmodule : hpp_host_parallel_port

// ===== pkg/hpp_pkg.sv
// Shared constants and types for the host parallel port
package hpp_pkg;

    // ------------------------------------------------------------
    // CPU-side register map
    // ------------------------------------------------------------
    localparam logic [31:0] PORT_CONTROL_ADDR   = 32'h0188_0000;
    localparam logic [31:0] WRITE_ADDR_CPY_ADDR = 32'h0188_0004;
    localparam logic [31:0] READ_ADDR_CPY_ADDR  = 32'h0188_0008;
    localparam logic [31:0] XFER_REQ_CTRL_ADDR  = 32'h018a_0000;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
    localparam logic [31:0] TRCTL_RESET = 32'h0000_0000;
    localparam int          CTRL_HALF_SWAP_BIT  = 0;
    localparam int          CTRL_WBUF_FULL_BIT  = 3;
    localparam int          CTRL_FETCH_BUSY_BIT = 4;
    localparam int          TRCTL_PRI_LSB       = 0;
    localparam int          TRCTL_PRI_W         = 3;
    localparam logic [31:0] ADDR_STEP           = 32'h0000_0004;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int  CPU_PERIOD_NS    = 40;
    localparam real STB_LOW_MIN_NS   = 12.5;
    localparam int  STB_MIN_PERIODS  = 4;
    localparam int  STB_NS_CYC       = int'($ceil(STB_LOW_MIN_NS / CPU_PERIOD_NS));
    localparam int  STB_LOW_MIN_CYC  =
        (STB_NS_CYC > STB_MIN_PERIODS) ? STB_NS_CYC : STB_MIN_PERIODS;
    localparam int  STB_HIGH_MIN_CYC = STB_MIN_PERIODS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_CONTROL  = 2'b00,
        SEL_DATA_INC = 2'b01,
        SEL_ADDRESS  = 2'b10,
        SEL_DATA_FIX = 2'b11
    } hpp_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_HOLD  = 2'b10
    } hpp_state_t;

    typedef struct packed {
        logic        cs_n;
        logic        ds1;
        logic        ds2;
        logic        as_n;
        hpp_sel_t    sel;
        logic        rnw;
        logic        hw;
        logic        m16;
        logic [31:0] data;
    } hpp_pins_t;

    typedef struct packed {
        hpp_sel_t sel;
        logic     rnw;
        logic     hw;
    } hpp_cmd_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } hpp_dma_t;

    typedef struct packed {
        hpp_pins_t   s1;
        hpp_pins_t   s2;
        logic        stb_q;
        logic        as_q;
        hpp_cmd_t    cmd;
        logic        cmd_held;
        hpp_state_t  st;
        logic [31:0] ctrl;
        logic [31:0] waddr;
        logic [31:0] raddr;
        logic [31:0] trctl;
        logic [31:0] rdata;
        logic [31:0] wstage;
        logic [31:0] wbuf;
        logic [31:0] wbuf_addr;
        logic        wbuf_full;
        hpp_dma_t    dma;
        logic [31:0] hd_out;
        logic        hd_oe;
        logic        ready_n;
        logic        cpu_ack;
        logic [31:0] cpu_rdata;
    } hpp_regs_t;

endpackage : hpp_pkg
